// ==== logic/led_bank_pkg.sv ====
// Purpose: constants for the low-voltage led path and bank current control
// Assumes: 125 MHz clock, classic wishbone register access
// Notes: all offsets are byte addresses of aligned words
// How it works
// RULE1 - four pump modes: off, auto, 1x, 2x
// RULE2 - pump switches at fixed 1MHz in 2x
// RULE3 - disabled pump isolates supply from output
// RULE4 - pump disable leaves sink states unchanged
// RULE5 - auto starts 1x, goes 2x on low headroom
// RULE6 - auto 2x is sticky until mode change
// RULE7 - auto startup checks flying capacitor, else 1x
// RULE8 - forced 1x passes supply, never switches
// RULE9 - anode bits [6:2] default one, gate feedback
// RULE10 - anode bit selects shorted-led fault condition
// RULE11 - each sink has 8-bit code, 5-bit full scale
// RULE12 - each sink maps to one of four banks
// RULE13 - each bank picks exponential or linear mapping
// RULE14 - exponential curve from code, times pwm duty
// RULE15 - linear current is full scale times code/255
// RULE16 - eight startup, eight shutdown times, global
// RULE17 - startup ramps to set point, shutdown to zero
// RULE18 - eight ramp-up, eight ramp-down run-time times, global
// RULE19 - brightness write sets bank target directly
// RULE20 - per-bank pwm scaling, linear in duty
// RULE21 - external pwm should be 2kHz to 100kHz
// RULE22 - polarity bit inverts pwm input
// RULE23 - ramps step monotonically to target
// RULE24 - duty measured by counting high and low time
package led_bank_pkg;
   localparam int          NUM_SINKS      = 5;
   localparam int          NUM_BANKS      = 4;
   localparam int          CLK_HZ         = 125000000;
   localparam int          PUMP_HZ        = 1000000;
   localparam int          PUMP_HALF      = CLK_HZ / PUMP_HZ / 2;
   localparam int          RAMP_STEP_US   = 2;
   localparam int          RAMP_BASE      = CLK_HZ / 1000000 * RAMP_STEP_US;
   localparam logic [7:0]  ADDR_PUMP      = 8'h00;
   localparam logic [7:0]  ADDR_ANODE     = 8'h04;
   localparam logic [7:0]  ADDR_MAP       = 8'h08;
   localparam logic [7:0]  ADDR_TIMES     = 8'h0c;
   localparam logic [7:0]  ADDR_BANKCFG   = 8'h10;
   localparam logic [7:0]  ADDR_STATUS    = 8'h14;
   localparam logic [7:0]  ADDR_SINK0     = 8'h20;
   localparam logic [7:0]  ADDR_BANK0     = 8'h40;
   localparam logic [7:0]  ADDR_LEVEL0    = 8'h60;
   localparam logic [4:0]  ANODE_RESET    = 5'h1f;
   localparam int          ANODE_LSB      = 2;
   localparam int          BCFG_EN        = 0;
   localparam int          BCFG_LIN       = 1;
   localparam int          BCFG_PWM       = 2;
   localparam int          PUMP_POL_BIT   = 2;
   localparam int          DUTY_W         = 16;
   typedef enum logic [1:0] {
      MODE_OFF  = 2'h0,
      MODE_AUTO = 2'h1,
      MODE_1X   = 2'h2,
      MODE_2X   = 2'h3
   } pumpMode_t;
   typedef enum logic [3:0] {
      PS_IDLE  = 4'h1,
      PS_DET   = 4'h2,
      PS_PASS  = 4'h4,
      PS_DOUB  = 4'h8
   } pumpState_t;
endpackage

// ==== logic/bank_ramp.sv ====
// Purpose: one bank level ramp and current computation
// Assumes: step period chosen by the shared time settings
// Notes: level is 16-bit current in full-scale units
module bank_ramp
   import led_bank_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        enable,
   input  wire logic        linear,
   input  wire logic        pwmEn,
   input  wire logic [7:0]  code,
   input  wire logic [15:0] duty,
   input  wire logic [2:0]  startSel,
   input  wire logic [2:0]  stopSel,
   input  wire logic [2:0]  upSel,
   input  wire logic [2:0]  downSel,
   output logic [15:0]      level
);
   logic [15:0] level_q;
   logic [15:0] target;
   logic [15:0] mapped;
   logic [23:0] tick_q;
   logic [23:0] period;
   logic        started_q;
   logic [31:0] scaled;

   // exponential curve: straight segments between knee points, 32 codes apart
   function automatic logic [15:0] expKnee(input logic [3:0] k);
      case (k)
         4'h0:    expKnee = 16'h491a;
         4'h1:    expKnee = 16'h558a;
         4'h2:    expKnee = 16'h6417;
         4'h3:    expKnee = 16'h751d;
         4'h4:    expKnee = 16'h8909;
         4'h5:    expKnee = 16'ha058;
         4'h6:    expKnee = 16'hbb9e;
         4'h7:    expKnee = 16'hdb89;
         default: expKnee = 16'hffff;
      endcase
   endfunction

   function automatic logic [15:0] expMap(input logic [7:0] c);
      logic [15:0] lo;
      logic [15:0] hi;
      lo = expKnee({1'b0, c[7:5]});
      hi = expKnee(4'({1'b0, c[7:5]} + 4'h1));
      expMap = lo + 16'((21'(hi - lo) * 21'(c[4:0])) >> 5); // RULE14
   endfunction

   always_comb begin
      mapped = linear ? {c255(code)} : expMap(code); // RULE13 RULE15 RULE14
      scaled = 32'(mapped) * 32'(pwmEn ? duty : 16'hffff); // RULE20
      target = enable ? scaled[31:16] : 16'h0000; // RULE19 RULE17
   end

   function automatic logic [15:0] c255(input logic [7:0] c);
      c255 = {c, c};
   endfunction

   always_comb begin
      if (!started_q)
         period = 24'(RAMP_BASE) << (enable ? startSel : stopSel); // RULE16
      else if (target > level_q)
         period = 24'(RAMP_BASE) << upSel; // RULE18
      else
         period = 24'(RAMP_BASE) << downSel;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tick_q <= 24'h000000;
      end else if (tick_q >= period) begin
         tick_q <= 24'h000000;
      end else begin
         tick_q <= tick_q + 24'h000001;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         level_q <= 16'h0000;
         started_q <= 1'b0;
      end else begin
         if (level_q == target)
            started_q <= enable;
         if (!enable)
            started_q <= 1'b0;
         if (tick_q >= period) begin
            if (level_q < target)
               level_q <= (target - level_q > 16'h0100) ? level_q + 16'h0100 : target; // RULE23
            else if (level_q > target)
               level_q <= (level_q - target > 16'h0100) ? level_q - 16'h0100 : target;
         end
      end
   end

   assign level = level_q;
endmodule

// ==== logic/led_bank_current_control.sv ====
// Purpose: charge pump mode control, sink mapping, bank current ramps
// Assumes: wishbone classic slave, pins from analog front end
// Notes: pin inputs pass four flops, the last loading only when the two before it agree
//
// Added by the designer: the register offsets and the Wishbone interface to the registers.
module led_bank_current_control
   import led_bank_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        pwmIn,
   input  wire logic        capPresent,
   input  wire logic [4:0]  sinkLowHeadroom,
   input  wire logic [4:0]  sinkShortHigh,
   input  wire logic [4:0]  sinkShortLow,
   output logic             pumpSwitchA,
   output logic             pumpSwitchB,
   output logic             pumpPass,
   output logic             pumpConnect,
   output logic [4:0]       sinkEnable,
   output logic [39:0]      sinkCurrent,
   output logic [24:0]      sinkFullScale,
   output logic [4:0]       sinkShortFault
);
   import led_bank_pkg::*;

   logic        rst1_q, rstn;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst1_q <= 1'b0;
         rstn   <= 1'b0;
      end else begin
         rst1_q <= 1'b1;
         rstn   <= rst1_q;
      end
   end

   // pin synchronisers
   logic [11:0] s1_q, s2_q, s3_q, stab_q;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s1_q   <= 12'h000;
         s2_q   <= 12'h000;
         s3_q   <= 12'h000;
         stab_q <= 12'h000;
      end else begin
         s1_q <= {pwmIn, capPresent, sinkLowHeadroom, sinkShortHigh[4:0] ^ 5'h00};
         s2_q <= s1_q;
         s3_q <= s2_q;
         for (int i = 0; i < 12; i++)
            if (s2_q[i] == s3_q[i])
               stab_q[i] <= s3_q[i];
      end
   end

   logic [4:0] shortLowS1_q, shortLowS2_q, shortLowS3_q, shortLow_q;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         shortLowS1_q <= 5'h00;
         shortLowS2_q <= 5'h00;
         shortLowS3_q <= 5'h00;
         shortLow_q   <= 5'h00;
      end else begin
         shortLowS1_q <= sinkShortLow;
         shortLowS2_q <= shortLowS1_q;
         shortLowS3_q <= shortLowS2_q;
         for (int i = 0; i < 5; i++)
            if (shortLowS2_q[i] == shortLowS3_q[i])
               shortLow_q[i] <= shortLowS3_q[i];
      end
   end

   logic       pwmS, capS;
   logic [4:0] headS, shortHighS;
   assign pwmS       = stab_q[11];
   assign capS       = stab_q[10];
   assign headS      = stab_q[9:5];
   assign shortHighS = stab_q[4:0];

   // registers
   logic [1:0]  modeReg_q;
   logic        pwmPol_q;
   logic [4:0]  anode_q;
   logic [7:0]  sinkMap_q [NUM_SINKS];
   logic [7:0]  sinkCode_q [NUM_SINKS];
   logic [4:0]  sinkFs_q [NUM_SINKS];
   logic [4:0]  sinkOn_q;
   logic [11:0] times_q;
   logic [2:0]  bankCfg_q [NUM_BANKS];
   logic [7:0]  bankCode_q [NUM_BANKS];
   logic [15:0] level [NUM_BANKS];
   pumpState_t  pstate_q;
   logic [15:0] dutyVal_q;

   // wishbone slave, ack one cycle after a request is taken
   logic req;
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;

   // one word of a per-sink or per-bank block
   function automatic logic hitWord(input logic [7:0] a, input logic [7:0] base,
                                    input int idx);
      hitWord = (a == base + 8'(4 * idx));
   endfunction

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         modeReg_q <= MODE_OFF;
         pwmPol_q  <= 1'b0;
         anode_q   <= ANODE_RESET; // RULE9
         times_q   <= 12'h000;
         sinkOn_q  <= 5'h00;
         for (int i = 0; i < NUM_SINKS; i++) begin
            sinkMap_q[i]  <= 8'h00;
            sinkCode_q[i] <= 8'h00;
            sinkFs_q[i]   <= 5'h00;
         end
         for (int b = 0; b < NUM_BANKS; b++) begin
            bankCfg_q[b]  <= 3'h0;
            bankCode_q[b] <= 8'h00;
         end
      end else if (req && wb_we_i && wb_sel_i[0]) begin
         if (wb_adr_i == ADDR_PUMP) begin
            modeReg_q <= wb_dat_i[1:0]; // RULE1
            pwmPol_q  <= wb_dat_i[PUMP_POL_BIT]; // RULE22
         end
         if (wb_adr_i == ADDR_ANODE)
            anode_q <= wb_dat_i[ANODE_LSB +: 5];
         if (wb_adr_i == ADDR_MAP)
            sinkOn_q <= wb_dat_i[4:0];
         if (wb_adr_i == ADDR_TIMES && wb_sel_i[1])
            times_q <= wb_dat_i[11:0]; // RULE16 RULE18
         for (int i = 0; i < NUM_SINKS; i++)
            if (hitWord(wb_adr_i, ADDR_SINK0, i)) begin
               sinkCode_q[i] <= wb_dat_i[7:0]; // RULE11
               if (wb_sel_i[1])
                  sinkFs_q[i] <= wb_dat_i[12:8];
               if (wb_sel_i[2])
                  sinkMap_q[i] <= {6'h00, wb_dat_i[17:16]}; // RULE12
            end
         for (int b = 0; b < NUM_BANKS; b++) begin
            if (hitWord(wb_adr_i, ADDR_BANK0, b))
               bankCode_q[b] <= wb_dat_i[7:0]; // RULE19
            if (wb_adr_i == ADDR_BANKCFG && wb_sel_i[b])
               bankCfg_q[b] <= wb_dat_i[8 * b +: 3];
         end
      end
   end

   // read data decode
   logic [31:0] rdata;
   always_comb begin
      rdata = 32'h00000000;
      unique case (wb_adr_i)
         ADDR_PUMP:    rdata = {24'h0, pstate_q, 1'b0, pwmPol_q, modeReg_q};
         ADDR_ANODE:   rdata = {25'h0, anode_q, 2'h0};
         ADDR_MAP:     rdata = {27'h0, sinkOn_q};
         ADDR_TIMES:   rdata = {20'h0, times_q};
         ADDR_BANKCFG: rdata = {5'h0, bankCfg_q[3], 5'h0, bankCfg_q[2],
                                5'h0, bankCfg_q[1], 5'h0, bankCfg_q[0]};
         ADDR_STATUS:  rdata = {11'h0, sinkShortFault, dutyVal_q};
         default: begin
            for (int i = 0; i < NUM_SINKS; i++)
               if (hitWord(wb_adr_i, ADDR_SINK0, i))
                  rdata = {14'h0, sinkMap_q[i][1:0], 3'h0, sinkFs_q[i], sinkCode_q[i]};
            for (int b = 0; b < NUM_BANKS; b++) begin
               if (hitWord(wb_adr_i, ADDR_BANK0, b))
                  rdata = {24'h0, bankCode_q[b]};
               if (hitWord(wb_adr_i, ADDR_LEVEL0, b))
                  rdata = {16'h0, level[b]};
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= req;
         if (req)
            wb_dat_o <= rdata;
      end
   end

   // charge pump mode control
   logic [1:0] modeSeen_q;
   logic       headTrip;
   assign headTrip = |(headS & anode_q & sinkOn_q); // RULE5 RULE9

   // capacitor sensed once while detecting, held for the auto run
   logic       capOk_q;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         capOk_q <= 1'b0;
      end else if (pstate_q == PS_DET) begin
         capOk_q <= capS; // RULE7
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pstate_q   <= PS_IDLE;
         modeSeen_q <= MODE_OFF;
      end else begin
         modeSeen_q <= modeReg_q;
         if (modeSeen_q != modeReg_q)
            pstate_q <= PS_IDLE;
         else begin
            unique case (pstate_q)
               PS_IDLE: begin
                  unique case (modeReg_q)
                     MODE_OFF:  pstate_q <= PS_IDLE; // RULE3
                     MODE_AUTO: pstate_q <= PS_DET; // RULE7
                     MODE_1X:   pstate_q <= PS_PASS; // RULE8
                     MODE_2X:   pstate_q <= PS_DOUB;
                  endcase
               end
               PS_DET: pstate_q <= PS_PASS; // RULE5 RULE7
               PS_PASS:
                  if (modeReg_q == MODE_AUTO && capOk_q && headTrip)
                     pstate_q <= PS_DOUB; // RULE5
               PS_DOUB: pstate_q <= PS_DOUB; // RULE6
               default: pstate_q <= PS_IDLE;
            endcase
         end
      end
   end

   logic [7:0] pumpDiv_q;
   logic       phase_q;
   logic       halfDone;
   logic       doubRun_q;
   assign halfDone = (pumpDiv_q == 8'(PUMP_HALF - 1));
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pumpDiv_q <= 8'h00;
         phase_q   <= 1'b0;
      end else if (halfDone) begin
         pumpDiv_q <= 8'h00;
         phase_q   <= !phase_q; // RULE2
      end else begin
         pumpDiv_q <= pumpDiv_q + 8'h01;
      end
   end

   // switching starts on a phase boundary, so no runt first pulse
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         doubRun_q   <= 1'b0;
         pumpSwitchA <= 1'b0;
         pumpSwitchB <= 1'b0;
         pumpPass    <= 1'b0;
         pumpConnect <= 1'b0;
      end else begin
         if (pstate_q != PS_DOUB)
            doubRun_q <= 1'b0;
         else if (halfDone)
            doubRun_q <= 1'b1;
         pumpSwitchA <= (pstate_q == PS_DOUB) && doubRun_q && phase_q; // RULE2
         pumpSwitchB <= (pstate_q == PS_DOUB) && doubRun_q && !phase_q;
         pumpPass    <= (pstate_q == PS_PASS); // RULE8
         pumpConnect <= (pstate_q == PS_PASS) || (pstate_q == PS_DOUB); // RULE3
      end
   end

   // duty measurement
   logic        pwmPol;
   logic        pwmPrev_q;
   logic [15:0] hiCnt_q, loCnt_q;
   assign pwmPol = pwmS ^ pwmPol_q; // RULE22
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pwmPrev_q <= 1'b0;
         hiCnt_q   <= 16'h0000;
         loCnt_q   <= 16'h0000;
         dutyVal_q <= 16'hffff;
      end else begin
         pwmPrev_q <= pwmPol;
         if (pwmPol && !pwmPrev_q) begin
            dutyVal_q <= ((hiCnt_q | loCnt_q) == 16'h0000) ? 16'hffff :
                         16'((32'(hiCnt_q) << 16) / (32'(hiCnt_q) + 32'(loCnt_q))); // RULE24
            hiCnt_q <= 16'h0001;
            loCnt_q <= 16'h0000;
         end else if (pwmPol) begin
            if (hiCnt_q != 16'hffff)
               hiCnt_q <= hiCnt_q + 16'h0001;
         end else if (loCnt_q != 16'hffff) begin
            loCnt_q <= loCnt_q + 16'h0001;
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_BANKS; g++) begin : gBank
         bank_ramp uRamp (
            .clk      (clk),
            .rstn     (rstn),
            .enable   (bankCfg_q[g][BCFG_EN]),
            .linear   (bankCfg_q[g][BCFG_LIN]), // RULE13
            .pwmEn    (bankCfg_q[g][BCFG_PWM]), // RULE20
            .code     (bankCode_q[g]),
            .duty     (dutyVal_q),
            .startSel (times_q[2:0]),
            .stopSel  (times_q[5:3]),
            .upSel    (times_q[8:6]),
            .downSel  (times_q[11:9]),
            .level    (level[g])
         );
      end
   endgenerate

   // sink outputs, unaffected by pump state
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sinkEnable     <= 5'h00;
         sinkCurrent    <= 40'h0000000000;
         sinkFullScale  <= 25'h0000000;
      end else begin
         sinkEnable <= sinkOn_q; // RULE4
         for (int i = 0; i < NUM_SINKS; i++) begin
            sinkCurrent[8 * i +: 8] <= 8'((16'(level[sinkMap_q[i][1:0]][15:8])
                                         * 16'(sinkCode_q[i]) + 16'h00ff) >> 8); // RULE12
            sinkFullScale[5 * i +: 5] <= sinkFs_q[i]; // RULE11
         end
      end
   end

   // shorted-led flags, detector chosen by where the anode sits
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sinkShortFault <= 5'h00;
      end else begin
         for (int i = 0; i < NUM_SINKS; i++)
            sinkShortFault[i] <= sinkOn_q[i] &&
                                 (anode_q[i] ? shortHighS[i] : shortLow_q[i]); // RULE10
      end
   end
endmodule

// ==== verification/led_bank_props.sv ====
// Purpose: port assertions for led bank current control
// Assumes: ack one cycle after a taken request
// Notes: pump mode tracked from accepted bus writes
module led_bank_props
   import led_bank_pkg::*;
(
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        capPresent,
   input wire logic        pumpSwitchA,
   input wire logic        pumpSwitchB,
   input wire logic        pumpPass,
   input wire logic        pumpConnect,
   input wire logic [4:0]  sinkEnable
);
   logic [1:0] mode_q;
   logic [3:0] quiet_q;
   logic       prevA_q;
   logic       seen_q;
   logic [7:0] run_q;
   wire        pumpWr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o
                        && wb_adr_i == ADDR_PUMP && wb_sel_i[0];
   wire        settled = quiet_q == 4'hf;
   wire        chg = pumpSwitchA != prevA_q;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // pump mode and cycles since it was written
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mode_q <= 2'h0;
         quiet_q <= 4'h0;
      end else if (pumpWr) begin
         mode_q <= wb_dat_i[1:0];
         quiet_q <= 4'h0;
      end else if (!settled) begin
         quiet_q <= quiet_q + 4'h1;
      end
   end
   // length of each phase of switch a
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prevA_q <= 1'b0;
         seen_q <= 1'b0;
         run_q <= 8'h0;
      end else begin
         prevA_q <= pumpSwitchA;
         seen_q <= pumpWr ? 1'b0 : (chg ? 1'b1 : seen_q);
         run_q <= chg ? 8'h1 : (run_q == 8'hff ? run_q : run_q + 8'h1);
      end
   end
   sequence busReq;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence ackPulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   a_ack_pulse: assert property (busReq |=> ackPulse)
      else $error("ack not one pulse after request");
   a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_unmapped_zero: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && wb_ack_o
      && wb_adr_i >= 8'h70 |-> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   a_off_isolated: assert property (settled && mode_q == MODE_OFF
      |-> !pumpConnect && !pumpSwitchA && !pumpSwitchB)
      else $error("disabled pump not isolated");
   a_onex_pass: assert property (settled && mode_q == MODE_1X
      |-> pumpPass && pumpConnect && !pumpSwitchA && !pumpSwitchB)
      else $error("forced 1x not passing");
   a_phase_split: assert property (pumpSwitchA |-> !pumpSwitchB)
      else $error("both pump phases on");
   a_switch_rate: assert property (mode_q == MODE_2X && seen_q && chg
      |-> run_q == PUMP_HALF)
      else $error("pump phase length wrong");
   a_sinks_kept: assert property ($fell(pumpConnect) |-> $stable(sinkEnable))
      else $error("sink enables moved with pump");
   a_no_cap: assert property (settled && mode_q == MODE_AUTO && !capPresent
      |-> !pumpSwitchA && !pumpSwitchB)
      else $error("pump switching without capacitor");
endmodule

bind led_bank_current_control led_bank_props u_props (.*);

// ==== verification/pwm_source.sv ====
// Purpose: external pwm source for the bank current bench
// Assumes: lengths in clock cycles, both above zero
// Notes: line rests low while stopped
module pwm_source (
   input  wire logic        clk,
   input  wire logic        run,
   input  wire logic [15:0] highLen,
   input  wire logic [15:0] lowLen,
   output logic             pwmOut
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] cnt_q;
   always_ff @(posedge clk) begin
      if (!run) begin
         cnt_q <= 16'h0;
         pwmOut <= 1'b0;
      end else if (cnt_q + 16'h1 >= (pwmOut ? highLen : lowLen)) begin
         cnt_q <= 16'h0;
         pwmOut <= !pwmOut;
      end else begin
         cnt_q <= cnt_q + 16'h1;
      end
   end
endmodule

// ==== verification/led_bank_current_control_tb.sv ====
// Purpose: bench for led bank current control
// Assumes: 125 MHz clock, wishbone classic access
// Notes: ramps use the shortest step period
module led_bank_current_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import led_bank_pkg::*;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h0;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        pwmIn;
   logic        capPresent = 1'b1;
   logic [4:0]  sinkLowHeadroom = 5'h0;
   logic [4:0]  sinkShortHigh = 5'h0;
   logic [4:0]  sinkShortLow = 5'h0;
   logic        pumpSwitchA, pumpSwitchB, pumpPass, pumpConnect;
   logic [4:0]  sinkEnable, sinkShortFault;
   logic [39:0] sinkCurrent;
   logic [24:0] sinkFullScale;
   logic        run = 1'b0;
   logic [31:0] q, d1;
   logic [3:0]  st [4] = '{4'h1, 4'h4, 4'h4, 4'h8};
   int          checks = 0;
   int          n_fail = 0;

   led_bank_current_control u_led_bank_current_control (.*);
   pwm_source u_pwm_source (.clk(clk), .run(run), .highLen(16'h138), .lowLen(16'h3aa),
                            .pwmOut(pwmIn));

   always #4 clk = ~clk;

   task automatic results();
      if (n_fail == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
      int n;
      n = 0;
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_sel_i <= 4'hf;
      wb_dat_i <= d;
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      r = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      if (n >= 50) begin
         n_fail++;
         results();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      xfer(1'b0, a, 32'h0, r);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic pumpState(input logic [3:0] e);
      logic [31:0] r;
      tick(20);
      rd(ADDR_PUMP, r);
      check(r[7:4], e);
   endtask
   task automatic ramp(input logic up, input logic [7:0] target);
      logic [7:0] prev;
      logic       mono;
      int         n;
      prev = sinkCurrent[7:0];
      mono = 1'b1;
      n = 0;
      while (sinkCurrent[7:0] !== target && n < 40000) begin
         @(posedge clk);
         if (up ? sinkCurrent[7:0] < prev : sinkCurrent[7:0] > prev) mono = 1'b0;
         prev = sinkCurrent[7:0];
         n++;
      end
      if (n >= 40000) begin
         n_fail++;
         results();
      end
      check(mono, 1'b1);
   endtask

   initial begin
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      tick(6);
      rd(ADDR_ANODE, q);
      check(q, 32'h7c);
      wr(8'h74, 32'hffff);
      rd(8'h74, q);
      check(q, 32'h0);
      wr(ADDR_MAP, 32'h1f);
      for (int m = 0; m < 4; m++) begin
         wr(ADDR_PUMP, 32'(m));
         tick(300);
         rd(ADDR_PUMP, q);
         check(q & 32'hf3, {24'h0, st[m], 2'h0, 2'(m)});
      end
      wr(ADDR_PUMP, 32'h0);
      wr(ADDR_PUMP, 32'h1);
      pumpState(4'h4);
      sinkLowHeadroom <= 5'h01;
      pumpState(4'h8);
      sinkLowHeadroom <= 5'h00;
      pumpState(4'h8);
      wr(ADDR_ANODE, 32'h78);
      wr(ADDR_PUMP, 32'h0);
      wr(ADDR_PUMP, 32'h1);
      sinkLowHeadroom <= 5'h01;
      pumpState(4'h4);
      wr(ADDR_ANODE, 32'h7c);
      wr(ADDR_PUMP, 32'h0);
      capPresent <= 1'b0;
      tick(10);
      wr(ADDR_PUMP, 32'h1);
      sinkLowHeadroom <= 5'h1f;
      pumpState(4'h4);
      sinkLowHeadroom <= 5'h00;
      capPresent <= 1'b1;
      wr(ADDR_PUMP, 32'h3);
      tick(300);
      wr(ADDR_PUMP, 32'h0);
      tick(20);
      check(sinkEnable, 5'h1f);
      sinkShortHigh <= 5'h01;
      sinkShortLow <= 5'h02;
      tick(10);
      check(sinkShortFault, 5'h01);
      wr(ADDR_ANODE, 32'h74);
      tick(2);
      check(sinkShortFault, 5'h03);
      wr(ADDR_ANODE, 32'h7c);
      sinkShortHigh <= 5'h00;
      sinkShortLow <= 5'h00;
      run <= 1'b1;
      tick(3000);
      rd(ADDR_STATUS, d1);
      check(d1[15:0] > 16'h3000 && d1[15:0] < 16'h5000, 1'b1);
      wr(ADDR_PUMP, 32'h4);
      tick(3000);
      rd(ADDR_STATUS, q);
      check(q[15:0] > 16'hb000 && q[15:0] < 16'hd000, 1'b1);
      wr(ADDR_TIMES, 32'hfff);
      rd(ADDR_TIMES, q);
      check(q & 32'hfff, 32'hfff);
      wr(ADDR_TIMES, 32'h0);
      wr(ADDR_SINK0, 32'h11fff);
      wr(ADDR_SINK0 + 8'h4, 32'h21fff);
      wr(ADDR_SINK0 + 8'h8, 32'h31fff);
      rd(ADDR_SINK0, q);
      check(q, 32'h11fff);
      check(sinkFullScale[4:0], 5'h1f);
      wr(ADDR_BANK0 + 8'h4, 32'h80);
      wr(ADDR_BANK0 + 8'h8, 32'h20);
      wr(ADDR_BANKCFG, 32'h10300);
      ramp(1'b1, 8'h80);
      check(sinkCurrent[7:0], 8'h80);
      check(sinkCurrent[15:8] > 8'h48 && sinkCurrent[15:8] < 8'h60, 1'b1);
      check(sinkCurrent[23:16], 8'h0);
      rd(ADDR_LEVEL0 + 8'h4, q);
      check(q[15:8], 8'h80);
      wr(ADDR_BANKCFG, 32'h0);
      ramp(1'b0, 8'h0);
      check(sinkCurrent[15:0], 16'h0);
      results();
   end
endmodule
